/* File: verilog/sps_pkg.sv */
package sps_pkg;
	localparam int unsigned NUM_PROGS   = 15;
	localparam int unsigned NUM_SEGS    = 15;
	localparam int unsigned AUX_W       = 4;
	localparam int unsigned SP_W        = 16;
	localparam int unsigned DUR_W       = 16;
	localparam int unsigned REP_W       = 10;
	localparam int unsigned ACC_W       = 32;
	localparam int unsigned REM_W       = 20;
	localparam logic [3:0]  BAD_INDEX   = 4'hf;
	localparam logic [3:0]  FIRST_SEG   = 4'h0;
	localparam logic [3:0]  LAST_SEG    = 4'he;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned SECOND_NS     = 1_000_000_000;
	localparam int unsigned CYC_PER_SEC   = SECOND_NS / CLK_PERIOD_NS;
	localparam int unsigned SEC_PER_MIN   = 60;
	localparam logic [31:0] RATE_DIV_MIN  = 32'h0000_003c;
	localparam logic [31:0] RATE_DIV_HOUR = 32'h0000_0e10;
	localparam logic [REP_W-1:0] ONE_REP  = 10'h001;
	localparam logic [15:0] SP_RESET      = 16'h0000;
	localparam logic [1:0]  STAT_IDLE     = 2'h0;
	localparam logic [1:0]  STAT_RUN      = 2'h1;
	localparam logic [1:0]  STAT_LOCKED   = 2'h2;
	localparam logic [1:0]  STAT_DONE     = 2'h3;
	typedef enum logic [1:0] {
		KIND_TIME  = 2'h0,
		KIND_RATE  = 2'h1,
		KIND_DWELL = 2'h2,
		KIND_END   = 2'h3
	} sps_kind_t;
	typedef enum logic [1:0] {
		LOCK_OFF   = 2'h0,
		LOCK_LOWER = 2'h1,
		LOCK_UPPER = 2'h2,
		LOCK_BOTH  = 2'h3
	} sps_lock_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_LOAD = 3'h2,
		ST_RUN  = 3'h4
	} sps_state_t;
endpackage

/* File: verilog/sps_tick.sv */
`timescale 1ns/10ps
`default_nettype none
module sps_tick #(
	parameter int unsigned N = 60
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset_n,
	// Count in and pulse out
	input  wire logic count_in,
	output var  logic tick_reg
);
	logic [31:0] cnt_reg;
	wire         wrap = (cnt_reg == 32'(N - 1));

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_reg  <= 32'h0000_0000;
			tick_reg <= 1'b0;
		end else begin
			tick_reg <= count_in && wrap;
			if (count_in) begin
				cnt_reg <= wrap ? 32'h0000_0000 : cnt_reg + 32'h0000_0001;
			end
		end
	end
endmodule
`default_nettype wire

/* File: verilog/sps_lock.sv */
`timescale 1ns/10ps
`default_nettype none
module sps_lock (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 reset_n,
	// Check inputs
	input  wire logic                 enable,
	input  wire logic [1:0]           mode,
	input  wire logic [15:0]          lock_value,
	input  wire logic signed [15:0]   setpoint,
	input  wire logic signed [15:0]   measured,
	// Lock flag
	output var  logic                 locked_reg
);
	// Two guard bits keep both limits exact for any set point and lock value.
	wire logic signed [17:0] lo_lim = {{2{setpoint[15]}}, setpoint} - {2'b00, lock_value};
	wire logic signed [17:0] hi_lim = {{2{setpoint[15]}}, setpoint} + {2'b00, lock_value};
	wire logic signed [17:0] pv_x   = {{2{measured[15]}}, measured};
	wire below   = pv_x < lo_lim;
	wire above   = pv_x > hi_lim;
	wire use_lo  = (mode == sps_pkg::LOCK_LOWER) || (mode == sps_pkg::LOCK_BOTH);
	wire use_hi  = (mode == sps_pkg::LOCK_UPPER) || (mode == sps_pkg::LOCK_BOTH);
	// A zero lock value or lock mode off disables the check entirely.
	wire checked = enable && (mode != sps_pkg::LOCK_OFF) && (lock_value != 16'h0000);
	wire trip    = checked && ((use_lo && below) || (use_hi && above));

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			locked_reg <= 1'b0;
		end else begin
			locked_reg <= trip;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_lock_gate_off: assert property (
		!checked |=> !locked_reg) else $error("lock set while check disabled");
	a_lock_lower_trip: assert property (
		(checked && mode == sps_pkg::LOCK_LOWER) |=> (locked_reg == $past(below)))
		else $error("lower lock wrong");
	a_lock_upper_trip: assert property (
		(checked && mode == sps_pkg::LOCK_UPPER) |=> (locked_reg == $past(above)))
		else $error("upper lock wrong");
	a_lock_both_trip: assert property (
		(checked && mode == sps_pkg::LOCK_BOTH) |=> (locked_reg == ($past(below) || $past(above))))
		else $error("two-sided lock wrong");
endmodule
`default_nettype wire

/* File: verilog/sps_sequencer.sv */
`timescale 1ns/10ps
`default_nettype none
module sps_sequencer #(
	parameter int unsigned CYC_PER_SEC = sps_pkg::CYC_PER_SEC
) (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 reset_n,
	// Program parameter write
	input  wire logic                 cfg_prog_we,
	input  wire logic [3:0]           cfg_prog_sel,
	input  wire logic                 cfg_start_measured,
	input  wire logic signed [15:0]   cfg_initial_target_value,
	input  wire logic                 cfg_dur_hours,
	input  wire logic                 cfg_rate_per_hour,
	input  wire logic [1:0]           cfg_lock_mode,
	input  wire logic [9:0]           cfg_repeats,
	// Segment write
	input  wire logic                 cfg_seg_we,
	input  wire logic [3:0]           cfg_seg_sel,
	input  wire logic [1:0]           cfg_seg_kind,
	input  wire logic signed [15:0]   cfg_seg_end_sp,
	input  wire logic [15:0]          cfg_seg_duration,
	input  wire logic [15:0]          cfg_seg_rate,
	input  wire logic [15:0]          cfg_seg_lock,
	input  wire logic [3:0]           cfg_seg_aux,
	// Run control
	input  wire logic                 program_mode,
	input  wire logic [3:0]           active_prog,
	input  wire logic                 run_start,
	input  wire logic                 run_stop,
	// Control loop
	input  wire logic signed [15:0]   measured_value,
	input  wire logic signed [15:0]   fixed_setpoint,
	output var  logic signed [15:0]   working_sp_reg,
	// Outputs and status
	output var  logic [3:0]           aux_out_reg,
	output var  logic                 run_ind_reg,
	output var  logic                 running_reg,
	output var  logic [1:0]           run_status_reg,
	output var  logic [3:0]           prog_reg,
	output var  logic [3:0]           seg_reg,
	output var  logic [9:0]           reps_reg,
	output var  logic [15:0]          elapsed_reg,
	output var  logic [15:0]          seg_remain_reg,
	output var  logic [19:0]          prog_remain_reg,
	output var  logic                 locked_reg
);
	localparam int unsigned NP = sps_pkg::NUM_PROGS;
	localparam int unsigned NS = sps_pkg::NUM_SEGS;

	// Program store.
	logic [1:0]          kind_mem  [NP][NS];
	logic signed [15:0]  end_mem   [NP][NS];
	logic [15:0]         dur_mem   [NP][NS];
	logic [15:0]         rate_mem  [NP][NS];
	logic [15:0]         lockv_mem [NP][NS];
	logic [3:0]          aux_mem   [NP][NS];
	logic                src_mem   [NP];
	logic signed [15:0]  init_mem  [NP];
	logic                dunit_mem [NP];
	logic                runit_mem [NP];
	logic [1:0]          lmode_mem [NP];
	logic [9:0]          rep_mem   [NP];

	sps_pkg::sps_state_t state_reg, state_next;
	logic [3:0]          prog_next, seg_next;
	logic [9:0]          reps_next;
	logic signed [15:0]  sp_reg, sp_next;
	logic [31:0]         acc_reg, acc_next, inc_reg, inc_next, div_reg, div_next;
	logic [15:0]         elapsed_next;
	logic                running_next, done_reg, done_next, blink_reg;
	logic [19:0]         later_sum;
	logic                sum_stop;
	logic                sec_tick, min_tick;

	wire prog_wr  = cfg_prog_we && (cfg_prog_sel != sps_pkg::BAD_INDEX);
	wire seg_wr   = prog_wr == 1'b0 && cfg_seg_we && (cfg_prog_sel != sps_pkg::BAD_INDEX)
		&& (cfg_seg_sel != sps_pkg::BAD_INDEX);
	wire st_idle  = (state_reg == sps_pkg::ST_IDLE);
	wire st_load  = (state_reg == sps_pkg::ST_LOAD);
	wire st_run   = (state_reg == sps_pkg::ST_RUN);
	wire start_ok = st_idle && run_start && (active_prog != sps_pkg::BAD_INDEX);

	// Fields of the segment under way.
	wire sps_pkg::sps_kind_t kind_w = sps_pkg::sps_kind_t'(kind_mem[prog_reg][seg_reg]);
	wire logic signed [15:0] tgt_w   = end_mem[prog_reg][seg_reg];
	wire logic [15:0]        dur_w   = dur_mem[prog_reg][seg_reg];
	wire logic [15:0]        lockv_w = lockv_mem[prog_reg][seg_reg];
	wire logic [3:0]         aux_w   = aux_mem[prog_reg][seg_reg];
	wire is_time  = (kind_w == sps_pkg::KIND_TIME);
	wire is_rate  = (kind_w == sps_pkg::KIND_RATE);
	wire frozen   = locked_reg;
	// Durations count minutes in hr:min and seconds in min:sec.
	wire unit_tick = dunit_mem[prog_reg] ? min_tick : sec_tick;
	wire adv_tick  = st_run && !frozen && unit_tick;
	wire acc_tick  = st_run && !frozen && (is_rate ? sec_tick : (is_time && unit_tick));
	wire can_step  = st_run && !frozen && (is_time || is_rate) && (div_reg != 32'h0000_0000)
		&& (acc_reg >= div_reg) && (sp_reg != tgt_w);
	wire step_up   = tgt_w > sp_reg;
	wire seg_done  = st_run && !frozen
		&& (is_rate ? (sp_reg == tgt_w) : (elapsed_reg >= dur_w));
	wire end_hit   = !run_stop && ((st_load && kind_w == sps_pkg::KIND_END)
		|| (seg_done && seg_reg == sps_pkg::LAST_SEG));
	wire logic signed [16:0] diff_w = {tgt_w[15], tgt_w} - {sp_reg[15], sp_reg};
	wire logic [16:0]        mag_w  = diff_w[16] ? 17'(-diff_w) : 17'(diff_w);
	wire logic [31:0] rate_div = runit_mem[prog_reg] ? sps_pkg::RATE_DIV_HOUR
		: sps_pkg::RATE_DIV_MIN;
	wire logic [15:0] seg_left = (!is_rate && dur_w > elapsed_reg) ? dur_w - elapsed_reg
		: 16'h0000;

	sps_tick #(.N(CYC_PER_SEC)) u_sec_tick (
		.clk      (clk),
		.reset_n  (reset_n),
		.count_in (1'b1),
		.tick_reg (sec_tick)
	);

	sps_tick #(.N(sps_pkg::SEC_PER_MIN)) u_min_tick (
		.clk      (clk),
		.reset_n  (reset_n),
		.count_in (sec_tick),
		.tick_reg (min_tick)
	);

	sps_lock u_lock (
		.clk        (clk),
		.reset_n    (reset_n),
		.enable     (st_run),
		.mode       (lmode_mem[prog_reg]),
		.lock_value (lockv_w),
		.setpoint   (sp_reg),
		.measured   (measured_value),
		.locked_reg (locked_reg)
	);

	// Kinds and program parameters reset so an unwritten program ends at once.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int p = 0; p < NP; p++) begin
				src_mem[p]   <= 1'b0;
				init_mem[p]  <= sps_pkg::SP_RESET;
				dunit_mem[p] <= 1'b0;
				runit_mem[p] <= 1'b0;
				lmode_mem[p] <= sps_pkg::LOCK_OFF;
				rep_mem[p]   <= sps_pkg::ONE_REP;
				for (int s = 0; s < NS; s++) begin
					kind_mem[p][s] <= sps_pkg::KIND_END;
				end
			end
		end else if (prog_wr) begin
			src_mem[cfg_prog_sel]   <= cfg_start_measured;
			init_mem[cfg_prog_sel]  <= cfg_initial_target_value;
			dunit_mem[cfg_prog_sel] <= cfg_dur_hours;
			runit_mem[cfg_prog_sel] <= cfg_rate_per_hour;
			lmode_mem[cfg_prog_sel] <= cfg_lock_mode;
			rep_mem[cfg_prog_sel]   <= cfg_repeats;
		end else if (seg_wr) begin
			kind_mem[cfg_prog_sel][cfg_seg_sel] <= cfg_seg_kind;
		end
	end

	always_ff @(posedge clk) begin
		if (seg_wr) begin
			end_mem[cfg_prog_sel][cfg_seg_sel]   <= cfg_seg_end_sp;
			dur_mem[cfg_prog_sel][cfg_seg_sel]   <= cfg_seg_duration;
			rate_mem[cfg_prog_sel][cfg_seg_sel]  <= cfg_seg_rate;
			lockv_mem[cfg_prog_sel][cfg_seg_sel] <= cfg_seg_lock;
			aux_mem[cfg_prog_sel][cfg_seg_sel]   <= cfg_seg_aux;
		end
	end

	// Remaining program time sums the timed segments after the current one.
	always_comb begin
		later_sum = 20'h0_0000;
		sum_stop  = 1'b0;
		for (int i = 0; i < NS; i++) begin
			if (i > int'(seg_reg)) begin
				if (kind_mem[prog_reg][i] == sps_pkg::KIND_END) begin
					sum_stop = 1'b1;
				end else if (!sum_stop && kind_mem[prog_reg][i] != sps_pkg::KIND_RATE) begin
					later_sum = later_sum + {4'h0, dur_mem[prog_reg][i]};
				end
			end
		end
	end

	always_comb begin
		state_next   = state_reg;
		prog_next    = prog_reg;
		seg_next     = seg_reg;
		reps_next    = reps_reg;
		sp_next      = sp_reg;
		acc_next     = acc_reg;
		inc_next     = inc_reg;
		div_next     = div_reg;
		elapsed_next = elapsed_reg;
		running_next = running_reg;
		done_next    = done_reg;
		unique case (state_reg)
			sps_pkg::ST_IDLE: begin
				if (start_ok) begin
					state_next   = sps_pkg::ST_LOAD;
					prog_next    = active_prog;
					seg_next     = sps_pkg::FIRST_SEG;
					reps_next    = rep_mem[active_prog];
					sp_next      = src_mem[active_prog] ? measured_value
						: init_mem[active_prog];
					running_next = 1'b1;
					done_next    = 1'b0;
				end
			end
			sps_pkg::ST_LOAD: begin
				if (run_stop) begin
					state_next   = sps_pkg::ST_IDLE;
					running_next = 1'b0;
				end else if (kind_w != sps_pkg::KIND_END) begin
					state_next   = sps_pkg::ST_RUN;
					acc_next     = 32'h0000_0000;
					elapsed_next = 16'h0000;
					inc_next     = is_time ? {15'h0000, mag_w}
						: (is_rate ? {16'h0000, rate_mem[prog_reg][seg_reg]} : 32'h0000_0000);
					div_next     = is_time ? {16'h0000, dur_w} : rate_div;
				end
			end
			sps_pkg::ST_RUN: begin
				if (run_stop) begin
					state_next   = sps_pkg::ST_IDLE;
					running_next = 1'b0;
				end else begin
					elapsed_next = elapsed_reg + {15'h0000, adv_tick};
					acc_next     = acc_reg + (acc_tick ? inc_reg : 32'h0000_0000)
						- (can_step ? div_reg : 32'h0000_0000);
					if (can_step) begin
						sp_next = step_up ? sp_reg + 16'sh0001 : sp_reg - 16'sh0001;
					end
					if (seg_done) begin
						if (is_time) begin
							sp_next = tgt_w;
						end
						seg_next   = seg_reg + 4'h1;
						state_next = sps_pkg::ST_LOAD;
					end
				end
			end
			default: begin
				state_next   = sps_pkg::ST_IDLE;
				running_next = 1'b0;
			end
		endcase
		if (end_hit) begin
			seg_next = sps_pkg::FIRST_SEG;
			if (reps_reg > sps_pkg::ONE_REP) begin
				state_next = sps_pkg::ST_LOAD;
				reps_next  = reps_reg - sps_pkg::ONE_REP;
			end else begin
				seg_next     = seg_reg;
				state_next   = sps_pkg::ST_IDLE;
				running_next = 1'b0;
				done_next    = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg   <= sps_pkg::ST_IDLE;
			prog_reg    <= 4'h0;
			seg_reg     <= sps_pkg::FIRST_SEG;
			reps_reg    <= 10'h000;
			sp_reg      <= sps_pkg::SP_RESET;
			acc_reg     <= 32'h0000_0000;
			inc_reg     <= 32'h0000_0000;
			div_reg     <= 32'h0000_0000;
			elapsed_reg <= 16'h0000;
			running_reg <= 1'b0;
			done_reg    <= 1'b0;
		end else begin
			state_reg   <= state_next;
			prog_reg    <= prog_next;
			seg_reg     <= seg_next;
			reps_reg    <= reps_next;
			sp_reg      <= sp_next;
			acc_reg     <= acc_next;
			inc_reg     <= inc_next;
			div_reg     <= div_next;
			elapsed_reg <= elapsed_next;
			running_reg <= running_next;
			done_reg    <= done_next;
		end
	end

	// Outputs and status registers.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			working_sp_reg  <= sps_pkg::SP_RESET;
			aux_out_reg     <= 4'h0;
			run_ind_reg     <= 1'b0;
			blink_reg       <= 1'b0;
			run_status_reg  <= sps_pkg::STAT_IDLE;
			seg_remain_reg  <= 16'h0000;
			prog_remain_reg <= 20'h0_0000;
		end else begin
			working_sp_reg  <= program_mode ? sp_reg : fixed_setpoint;
			aux_out_reg     <= (st_load || st_run) ? aux_w : aux_out_reg;
			blink_reg       <= sec_tick ? !blink_reg : blink_reg;
			run_ind_reg     <= running_reg && (!frozen || blink_reg);
			run_status_reg  <= st_idle ? (done_reg ? sps_pkg::STAT_DONE : sps_pkg::STAT_IDLE)
				: (frozen ? sps_pkg::STAT_LOCKED : sps_pkg::STAT_RUN);
			seg_remain_reg  <= st_run ? seg_left : 16'h0000;
			prog_remain_reg <= st_run ? later_sum + {4'h0, seg_left} : 20'h0_0000;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_seg_index_bound: assert property (
		seg_reg <= sps_pkg::LAST_SEG) else $error("segment index out of range");
	a_start_loads_first: assert property (
		start_ok |=> st_load && seg_reg == sps_pkg::FIRST_SEG && prog_reg == $past(active_prog))
		else $error("start did not load first segment");
	a_repeat_restart: assert property (
		(end_hit && reps_reg > sps_pkg::ONE_REP) |=> st_load && seg_reg == sps_pkg::FIRST_SEG
		&& reps_reg == $past(reps_reg) - sps_pkg::ONE_REP) else $error("repeat wrong");
	a_end_aux_hold: assert property (
		(st_load && end_hit && reps_reg <= sps_pkg::ONE_REP) |=> ##1 st_idle
		&& aux_out_reg == $past(aux_w, 2) && !running_reg) else $error("end aux wrong");
	a_run_indicator: assert property (
		running_reg == !st_idle) else $error("running flag mismatch");
	a_lock_freeze: assert property (
		(st_run && frozen) |=> $stable(sp_reg) && $stable(elapsed_reg))
		else $error("advance while locked");
	a_dwell_hold: assert property (
		(st_run && kind_w == sps_pkg::KIND_DWELL) |=> $stable(sp_reg))
		else $error("dwell moved set point");
	a_program_sp: assert property (
		program_mode |=> working_sp_reg == $past(sp_reg)) else $error("set point not followed");

	c_repeat_taken: cover property (end_hit && reps_reg > sps_pkg::ONE_REP);
	c_lock_seen: cover property (st_run && frozen);
	c_rate_done: cover property (seg_done && is_rate);
	c_run_finish: cover property (end_hit && reps_reg <= sps_pkg::ONE_REP);
endmodule
`default_nettype wire

/* File: verif/sps_loop_model.sv */
`timescale 1ns/10ps
`default_nettype none
module sps_loop_model (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               reset_n,
	// Set point from the sequencer and the deviation that the bench commands
	input  wire logic signed [15:0] working_sp,
	input  wire logic signed [15:0] offset,
	// Measured value back to the sequencer
	output var  logic signed [15:0] measured_value
);
	// The process settles one cycle after the set point at a commanded deviation.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			measured_value <= 16'sh0000;
		end else begin
			measured_value <= working_sp + offset;
		end
	end
endmodule
`default_nettype wire

/* File: verif/setpoint_program_sequencer_bench.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) check_val(32'(g), 32'(e))
module setpoint_program_sequencer_bench;
	logic               clk = 1'b0;
	logic               reset_n = 1'b0;
	logic               pwe = 1'b0, sm = 1'b0, dh = 1'b0, rph = 1'b0, swe = 1'b0;
	logic               pm = 1'b0, rs = 1'b0, rstop = 1'b0;
	logic [3:0]         psel = 4'h0, ssel = 4'h0, saux = 4'h0, ap = 4'h0;
	logic [1:0]         mode = 2'h0, kind = 2'h0;
	logic signed [15:0] init = 16'sh0000, esp = 16'sh0000, fsp = 16'sh0123, ofs = 16'sh0000;
	logic [15:0]        dur = 16'h0000, rate = 16'h0000, lk = 16'h0000;
	logic [9:0]         reps = 10'h001;
	logic signed [15:0] wsp, meas;
	logic [3:0]         auxo, prog, seg;
	logic               rind, run, lkd;
	logic [1:0]         stat;
	logic [9:0]         rr;
	logic [15:0]        el, srem;
	logic [19:0]        prem;
	int                 num_errors = 0, checks_done = 0, cycles = 0;
	sps_sequencer #(.CYC_PER_SEC(10)) sps_sequencer_inst (
		.clk(clk), .reset_n(reset_n), .cfg_prog_we(pwe), .cfg_prog_sel(psel),
		.cfg_start_measured(sm), .cfg_initial_target_value(init), .cfg_dur_hours(dh),
		.cfg_rate_per_hour(rph), .cfg_lock_mode(mode), .cfg_repeats(reps),
		.cfg_seg_we(swe), .cfg_seg_sel(ssel), .cfg_seg_kind(kind), .cfg_seg_end_sp(esp),
		.cfg_seg_duration(dur), .cfg_seg_rate(rate), .cfg_seg_lock(lk), .cfg_seg_aux(saux),
		.program_mode(pm), .active_prog(ap), .run_start(rs), .run_stop(rstop),
		.measured_value(meas), .fixed_setpoint(fsp), .working_sp_reg(wsp),
		.aux_out_reg(auxo), .run_ind_reg(rind), .running_reg(run), .run_status_reg(stat),
		.prog_reg(prog), .seg_reg(seg), .reps_reg(rr), .elapsed_reg(el),
		.seg_remain_reg(srem), .prog_remain_reg(prem), .locked_reg(lkd));
	sps_loop_model sps_loop_model_inst (
		.clk(clk), .reset_n(reset_n), .working_sp(wsp), .offset(ofs), .measured_value(meas));
	always #5 clk = ~clk;
	task automatic check_val(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// A hung wait is cut short well after the longest sequence should end.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			conclude();
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wprog(input logic [3:0] p, input logic s, input logic signed [15:0] i,
			input logic r, input logic [1:0] m, input logic [9:0] n);
		psel = p;
		sm = s;
		init = i;
		rph = r;
		mode = m;
		reps = n;
		pwe = 1'b1;
		cyc(1);
		pwe = 1'b0;
		cyc(1);
	endtask
	task automatic wseg(input logic [3:0] s, input logic [1:0] k, input logic signed [15:0] e,
			input logic [15:0] d, input logic [15:0] r, input logic [15:0] l, input logic [3:0] a);
		ssel = s;
		kind = k;
		esp = e;
		dur = d;
		rate = r;
		lk = l;
		saux = a;
		swe = 1'b1;
		cyc(1);
		swe = 1'b0;
		cyc(1);
	endtask
	task automatic start(input logic [3:0] p);
		ap = p;
		rs = 1'b1;
		cyc(1);
		rs = 1'b0;
	endtask
	task automatic wait_seg(input logic [3:0] s);
		while (seg !== s)
			cyc(1);
	endtask
	task automatic wait_idle();
		while (run !== 1'b0)
			cyc(1);
	endtask
	// Measured value equals set point plus offset, so the deviation is the offset itself.
	function automatic logic lockf(input int m, input int o, input int l);
		if (l == 0 || m == 0)
			return 1'b0;
		return ((m == 1 || m == 3) && o < -l) || ((m == 2 || m == 3) && o > l);
	endfunction
	initial begin
		logic signed [15:0] ini, tgt, mv;
		logic [3:0]         a0, a1, a2, mx;
		logic [15:0]        e0;
		logic               s0, s1;
		int                 err, tol, n, l, off;
		void'($urandom(70024));
		cyc(4);
		reset_n = 1'b1;
		cyc(1);
		`CHK(run, 1'b0);
		`CHK(auxo, 4'h0);
		`CHK(wsp, fsp);
		pm = 1'b1;
		$display("test reset done");
		ini = 16'(100 + $urandom % 20);
		tgt = ini + 16'(1 + $urandom % 40);
		a0 = 4'($urandom);
		a1 = 4'($urandom);
		a2 = 4'($urandom);
		wprog(4'h3, 1'b0, ini, 1'b0, sps_pkg::LOCK_OFF, 10'h002);
		wseg(4'h0, sps_pkg::KIND_TIME, tgt, 16'h0004, 16'h0000, 16'h0000, a0);
		wseg(4'h1, sps_pkg::KIND_DWELL, 16'sh0000, 16'h0002, 16'h0000, 16'h0000, a1);
		wseg(4'h2, sps_pkg::KIND_END, 16'sh0000, 16'h0000, 16'h0000, 16'h0000, a2);
		start(4'h3);
		cyc(2);
		`CHK(run, 1'b1);
		`CHK(prog, 4'h3);
		`CHK(rr, 10'h002);
		`CHK(stat, sps_pkg::STAT_RUN);
		`CHK(auxo, a0);
		while (el !== 16'h0002)
			cyc(1);
		tol = (int'(tgt) - int'(ini)) / 4 + 2;
		err = int'(wsp) - (int'(ini) + (int'(tgt) - int'(ini)) / 2);
		`CHK(err >= -tol && err <= tol, 1'b1);
		cyc(1);
		`CHK(el, 16'h0002);
		`CHK(srem, 16'h0002);
		`CHK(prem, 20'h0_0004);
		wait_seg(4'h1);
		cyc(1);
		`CHK(wsp, tgt);
		cyc(1);
		`CHK(auxo, a1);
		while (rr !== 10'h001)
			cyc(1);
		`CHK(seg, 4'h0);
		`CHK(run, 1'b1);
		wait_idle();
		cyc(2);
		`CHK(stat, sps_pkg::STAT_DONE);
		`CHK(auxo, a2);
		`CHK(wsp, tgt);
		$display("test ramp_repeat done");
		for (int u = 0; u < 2; u++) begin
			wprog(4'h5, 1'b0, 16'sh0000, 1'(u), sps_pkg::LOCK_OFF, 10'h001);
			wseg(4'h0, sps_pkg::KIND_RATE, 16'sh0003, 16'h0000, (u == 1) ? 16'h0e10 : 16'h003c,
				16'h0000, 4'h5);
			wseg(4'h1, sps_pkg::KIND_END, 16'sh0000, 16'h0000, 16'h0000, 16'h0000, 4'ha);
			start(4'h5);
			n = cycles;
			wait_seg(4'h1);
			`CHK(wsp, 16'sh0003);
			`CHK(cycles - n >= 20 && cycles - n <= 50, 1'b1);
			wait_idle();
			cyc(2);
		end
		// Durations in minutes: two units take between one and two minutes of ticks.
		dh = 1'b1;
		wprog(4'h5, 1'b0, 16'sh0000, 1'b0, sps_pkg::LOCK_OFF, 10'h001);
		dh = 1'b0;
		wseg(4'h0, sps_pkg::KIND_DWELL, 16'sh0000, 16'h0002, 16'h0000, 16'h0000, 4'h6);
		start(4'h5);
		n = cycles;
		wait_seg(4'h1);
		`CHK(cycles - n >= 600 && cycles - n <= 1210, 1'b1);
		wait_idle();
		cyc(2);
		$display("test rate_units done");
		start(4'hf);
		cyc(3);
		`CHK(run, 1'b0);
		wprog(4'h9, 1'b0, 16'sh0010, 1'b0, sps_pkg::LOCK_OFF, 10'h001);
		for (int s = 0; s < 16; s++)
			wseg(4'(s), (s == 15) ? sps_pkg::KIND_TIME : sps_pkg::KIND_DWELL, 16'sh0000,
				16'h0000, 16'h0000, 16'h0000, 4'(s));
		start(4'h9);
		mx = 4'h0;
		cyc(1);
		while (run !== 1'b0) begin
			if (seg > mx)
				mx = seg;
			cyc(1);
		end
		`CHK(mx, 4'he);
		$display("test segment_limit done");
		l = 5 + $urandom % 16;
		psel = 4'h0;
		wseg(4'h0, sps_pkg::KIND_DWELL, 16'sh0000, 16'h01f4, 16'h0000, 16'(l), 4'h3);
		wseg(4'h1, sps_pkg::KIND_END, 16'sh0000, 16'h0000, 16'h0000, 16'h0000, 4'h0);
		for (int m = 0; m < 4; m++) begin
			for (int k = 0; k < 4; k++) begin
				off = (k < 2) ? -(l + 1 - k) : (l + k - 2);
				ofs = 16'sh0000;
				psel = 4'h0;
				wprog(4'h0, 1'b1, 16'sh0777, 1'b0, 2'(m), 10'h001);
				cyc(3);
				mv = meas;
				start(4'h0);
				cyc(2);
				`CHK(wsp, mv);
				ofs = 16'(off);
				cyc(4);
				`CHK(lkd, lockf(m, off, l));
				if (lockf(m, off, l)) begin
					e0 = el;
					s0 = 1'b0;
					s1 = 1'b0;
					repeat (25) begin
						cyc(1);
						s0 |= (rind === 1'b0);
						s1 |= (rind === 1'b1);
					end
					`CHK(el, e0);
					`CHK(stat, sps_pkg::STAT_LOCKED);
					`CHK(wsp, mv);
					`CHK(s0 && s1, 1'b1);
				end
				rstop = 1'b1;
				cyc(1);
				rstop = 1'b0;
				cyc(3);
			end
		end
		$display("test deviation_lock done");
		conclude();
	end
endmodule
`default_nettype wire
